// ==== rtl/scr_pkg.sv ====
// Shared constants of the system-call interpreter and its caller
package scr_pkg;
	// Argument word fields
	localparam int OPC_MSB = 31;
	localparam int OPC_LSB = 24;
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 1;
	localparam int INLINE_BIT = 0;
	localparam int BLOCK_MSB = 15;
	localparam int BLOCK_LSB = 8;
	localparam int STALL_BIT = 2;
	localparam int HV_BIT = 1;
	localparam int STAT_MSB = 31;
	localparam int STAT_LSB = 28;
	// Opcodes and field values
	localparam logic [7:0] OPC_RESET = 8'h1B;
	localparam logic [7:0] OPC_ERASE_ROW = 8'h1C;
	localparam logic [6:0] TYPE_SYSTEM = 7'h00;
	localparam logic [6:0] TYPE_APP_CORE = 7'h01;
	localparam logic [7:0] BLOCK_ON = 8'h01;
	localparam logic [31:0] ROW_ADDR_OFS = 32'h0000_0004;
	// Result codes
	localparam logic [3:0] STAT_OK = 4'hA;
	localparam logic [3:0] STAT_ERR = 4'hF;
	localparam logic [27:0] ERR_NONE = 28'h000_0000;
	localparam logic [27:0] ERR_OPCODE = 28'h000_0001;
	localparam logic [27:0] ERR_TYPE = 28'h000_0002;
	localparam logic [27:0] ERR_BUSY = 28'h000_0003;
	localparam logic [27:0] ERR_INLINE = 28'h000_0004;
	// Caller register map (APB byte offsets)
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_ARG = 8'h04;
	localparam logic [7:0] A_RESULT = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h0C;
	localparam logic [7:0] A_IRQ_STAT = 8'h10;
	localparam logic [7:0] A_IRQ_MASK = 8'h14;
	localparam logic [7:0] A_PB_BASE = 8'h20;
	localparam int CTRL_GO = 0;
	localparam int CTRL_PTR_MODE = 1;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// ==== rtl/scr_if.sv ====
// Link between a caller and the system-call interpreter
`timescale 1ns/1ns
`default_nettype none
interface scr_if;
	logic call_go;
	logic [31:0] arg_wdata;
	logic [31:0] arg_rdata;
	logic busy;
	logic done;
	logic mem_req;
	logic mem_we;
	logic [31:0] mem_addr;
	logic [31:0] mem_wdata;
	logic [31:0] mem_rdata;
	logic mem_ack;

	modport device (
		input call_go, arg_wdata, mem_rdata, mem_ack,
		output arg_rdata, busy, done, mem_req, mem_we, mem_addr, mem_wdata
	);
	modport caller (
		output call_go, arg_wdata, mem_rdata, mem_ack,
		input arg_rdata, busy, done, mem_req, mem_we, mem_addr, mem_wdata
	);
endinterface
`default_nettype wire

// ==== rtl/scr_interp.sv ====
// System-call interpreter: reset and flash row-erase services
//
// Behaviour
// R1: Reset service raises system reset request bit
// R2: System reset spares the debug logic
// R3: Type bits 7:1 pick system or app core
// R4: Debug caller sends opcode inline, bit0 set
// R5: Core caller passes word-aligned parameter block pointer
// R6: Pointer call: opcode, type from block; ignore bit0
// R7: Result: status 31:28, error 27:0
// R8: Inline result to argument word, else block
// R9: Opcode 1C erases one row, 23:16 ignored
// R10: Bits 15:8 equal 01 make call blocking
// R11: Bit2 stalls all flash reads during erase
// R12: Bit1 selects hardware high-voltage sequencing
// R13: Word 0x04 addresses any byte of row
// R14: Caller raises supply above 0.99 V first
// R15: Caller orders voltage select around flash writes
// R16: Unknown opcode returns error, does nothing
`timescale 1ns/1ns
`default_nettype none
module scr_interp #(
	parameter int ROW_AW = 9
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Caller link
	scr_if.device lnk,
	// Reset requests
	output logic sys_reset_req,
	output logic app_core_reset_req,
	// Flash row erase
	output logic erase_start,
	output logic [31:0] erase_addr,
	output logic erase_hw_hv,
	input wire logic erase_done,
	output logic flash_read_stall,
	output logic control_core_stall
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD0,
		ST_DECODE,
		ST_RD1,
		ST_WAIT,
		ST_REPORT
	} scr_state_e;

	typedef enum logic [1:0] {
		RK_NONE,
		RK_SYSTEM,
		RK_APP
	} scr_rst_kind_e;

	scr_state_e state_reg;
	scr_rst_kind_e rst_kind_reg;
	logic [31:0] ipc_reg;
	logic [31:0] word0_reg;
	logic [31:0] ptr_reg;
	logic inline_reg;
	logic [31:0] result_reg;
	logic blocking_reg;
	logic stall_reg;
	logic hv_reg;
	logic [31:0] erase_addr_reg;
	logic erase_active_reg;
	logic report_fin;
	logic erase_go;
	logic [7:0] opcode;
	logic [6:0] rst_type;

	assign opcode = word0_reg[scr_pkg::OPC_MSB:scr_pkg::OPC_LSB];
	// Bit 0 is never part of the type field
	assign rst_type = word0_reg[scr_pkg::TYPE_MSB:scr_pkg::TYPE_LSB]; // R6
	assign report_fin = (state_reg == ST_REPORT) && (inline_reg || lnk.mem_ack);
	assign erase_go = (state_reg == ST_RD1) && lnk.mem_ack;

	// Parameter block access
	assign lnk.mem_req = (state_reg == ST_RD0) || (state_reg == ST_RD1)
		|| ((state_reg == ST_REPORT) && !inline_reg);
	assign lnk.mem_we = (state_reg == ST_REPORT);
	assign lnk.mem_addr = (state_reg == ST_RD1) ? ptr_reg + scr_pkg::ROW_ADDR_OFS : ptr_reg; // R13
	assign lnk.mem_wdata = result_reg; // R8
	assign lnk.busy = (state_reg != ST_IDLE);
	assign lnk.done = report_fin;
	assign lnk.arg_rdata = ipc_reg;

	// Command sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			rst_kind_reg <= RK_NONE;
			word0_reg <= scr_pkg::RESET_WORD;
			ptr_reg <= scr_pkg::RESET_WORD;
			inline_reg <= 1'b0;
			result_reg <= scr_pkg::RESET_WORD;
			blocking_reg <= 1'b0;
			stall_reg <= 1'b0;
			hv_reg <= 1'b0;
			erase_addr_reg <= scr_pkg::RESET_WORD;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (lnk.call_go) begin
						rst_kind_reg <= RK_NONE;
						inline_reg <= lnk.arg_wdata[scr_pkg::INLINE_BIT];
						word0_reg <= lnk.arg_wdata;
						ptr_reg <= {lnk.arg_wdata[31:2], 2'b00};
						if (lnk.arg_wdata[scr_pkg::INLINE_BIT]) begin
							state_reg <= ST_DECODE;
						end else begin
							state_reg <= ST_RD0; // R6
						end
					end
				end
				ST_RD0: begin
					if (lnk.mem_ack) begin
						word0_reg <= lnk.mem_rdata; // R6
						state_reg <= ST_DECODE;
					end
				end
				ST_DECODE: begin
					case (opcode)
						scr_pkg::OPC_RESET: begin
							state_reg <= ST_REPORT;
							if (rst_type == scr_pkg::TYPE_SYSTEM) begin
								rst_kind_reg <= RK_SYSTEM; // R3
								result_reg <= {scr_pkg::STAT_OK, scr_pkg::ERR_NONE};
							end else if (rst_type == scr_pkg::TYPE_APP_CORE) begin
								rst_kind_reg <= RK_APP; // R3
								result_reg <= {scr_pkg::STAT_OK, scr_pkg::ERR_NONE};
							end else begin
								result_reg <= {scr_pkg::STAT_ERR, scr_pkg::ERR_TYPE};
							end
						end
						scr_pkg::OPC_ERASE_ROW: begin
							// Bits 23:16 are not looked at
							if (inline_reg) begin
								result_reg <= {scr_pkg::STAT_ERR, scr_pkg::ERR_INLINE};
								state_reg <= ST_REPORT;
							end else if (erase_active_reg) begin
								result_reg <= {scr_pkg::STAT_ERR, scr_pkg::ERR_BUSY};
								state_reg <= ST_REPORT;
							end else begin
								blocking_reg <= (word0_reg[scr_pkg::BLOCK_MSB:scr_pkg::BLOCK_LSB]
									== scr_pkg::BLOCK_ON); // R10
								stall_reg <= word0_reg[scr_pkg::STALL_BIT]; // R11
								hv_reg <= word0_reg[scr_pkg::HV_BIT]; // R12
								state_reg <= ST_RD1; // R9
							end
						end
						default: begin
							result_reg <= {scr_pkg::STAT_ERR, scr_pkg::ERR_OPCODE}; // R16
							state_reg <= ST_REPORT;
						end
					endcase
				end
				ST_RD1: begin
					if (lnk.mem_ack) begin
						// Whole containing row
						erase_addr_reg <= {lnk.mem_rdata[31:ROW_AW], {ROW_AW{1'b0}}}; // R13
						if (blocking_reg) begin
							state_reg <= ST_WAIT; // R10
						end else begin
							result_reg <= {scr_pkg::STAT_OK, scr_pkg::ERR_NONE};
							state_reg <= ST_REPORT;
						end
					end
				end
				ST_WAIT: begin
					if (erase_done) begin
						result_reg <= {scr_pkg::STAT_OK, scr_pkg::ERR_NONE}; // R7
						state_reg <= ST_REPORT;
					end
				end
				ST_REPORT: begin
					if (report_fin) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Argument word: written by caller, result for inline calls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ipc_reg <= scr_pkg::RESET_WORD;
		end else if (lnk.call_go && state_reg == ST_IDLE) begin
			ipc_reg <= lnk.arg_wdata;
		end else if (report_fin && inline_reg) begin
			ipc_reg <= result_reg; // R8
		end
	end

	// Reset requests follow the reported result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_reset_req <= 1'b0;
			app_core_reset_req <= 1'b0;
		end else begin
			// Debug logic sits outside this request's reach
			sys_reset_req <= report_fin && (rst_kind_reg == RK_SYSTEM); // R1 R2
			app_core_reset_req <= report_fin && (rst_kind_reg == RK_APP); // R3
		end
	end

	// Erase launch and tracking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_start <= 1'b0;
			erase_active_reg <= 1'b0;
		end else begin
			erase_start <= erase_go; // R9
			if (erase_go) begin
				erase_active_reg <= 1'b1;
			end else if (erase_done) begin
				erase_active_reg <= 1'b0;
			end
		end
	end

	assign erase_addr = erase_addr_reg;
	assign erase_hw_hv = hv_reg; // R12
	assign flash_read_stall = erase_active_reg && stall_reg; // R11
	assign control_core_stall = (state_reg == ST_WAIT); // R10
endmodule
`default_nettype wire

// ==== rtl/scr_caller.sv ====
// Caller end: APB-controlled issuer holding the parameter block
`timescale 1ns/1ns
`default_nettype none
module scr_caller #(
	parameter int PB_DEPTH = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq,
	// Interpreter link
	scr_if.caller lnk
);
	localparam int PB_AW = $clog2(PB_DEPTH);

	logic [31:0] pb_mem [PB_DEPTH];
	logic ptr_mode_reg;
	logic [31:0] arg_reg;
	logic [31:0] launch_reg;
	logic go_reg;
	logic [31:0] result_reg;
	logic [1:0] irq_stat_reg;
	logic [1:0] irq_mask_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic wr;
	logic in_pb;
	logic mapped;
	logic [31:0] rd_mux;
	logic [PB_AW-1:0] apb_idx;
	logic [PB_AW-1:0] mem_idx;
	logic [1:0] irq_set;
	logic res_pend_reg;
	logic res_valid;
	logic [31:0] res_word;

	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign in_pb = (paddr >= scr_pkg::A_PB_BASE)
		&& (paddr < scr_pkg::A_PB_BASE + 8'(4 * PB_DEPTH));
	assign apb_idx = paddr[PB_AW+1:2];
	assign mem_idx = lnk.mem_addr[PB_AW+1:2];
	assign mapped = in_pb || paddr == scr_pkg::A_CTRL || paddr == scr_pkg::A_ARG
		|| paddr == scr_pkg::A_RESULT || paddr == scr_pkg::A_STATUS
		|| paddr == scr_pkg::A_IRQ_STAT || paddr == scr_pkg::A_IRQ_MASK;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (in_pb) begin
			rd_mux = pb_mem[apb_idx];
		end else begin
			case (paddr)
				scr_pkg::A_CTRL: rd_mux = {30'h0, ptr_mode_reg, 1'b0};
				scr_pkg::A_ARG: rd_mux = arg_reg;
				scr_pkg::A_RESULT: rd_mux = result_reg;
				scr_pkg::A_STATUS: rd_mux = {31'h0, lnk.busy};
				scr_pkg::A_IRQ_STAT: rd_mux = {30'h0, irq_stat_reg};
				scr_pkg::A_IRQ_MASK: rd_mux = {30'h0, irq_mask_reg};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= rd_mux;
		end
	end

	// Control registers and call launch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_mode_reg <= 1'b0;
			arg_reg <= scr_pkg::RESET_WORD;
			launch_reg <= scr_pkg::RESET_WORD;
			go_reg <= 1'b0;
			irq_mask_reg <= 2'h0;
		end else begin
			go_reg <= 1'b0;
			if (wr && paddr == scr_pkg::A_ARG) begin
				arg_reg <= pwdata;
			end
			if (wr && paddr == scr_pkg::A_IRQ_MASK) begin
				irq_mask_reg <= pwdata[1:0];
			end
			if (wr && paddr == scr_pkg::A_CTRL) begin
				ptr_mode_reg <= pwdata[scr_pkg::CTRL_PTR_MODE];
				if (pwdata[scr_pkg::CTRL_GO] && !lnk.busy && !go_reg) begin
					go_reg <= 1'b1;
					if (pwdata[scr_pkg::CTRL_PTR_MODE]) begin
						launch_reg <= {arg_reg[31:2], 2'b00}; // R5
					end else begin
						launch_reg <= {arg_reg[31:1], 1'b1}; // R4
					end
				end
			end
		end
	end

	assign lnk.call_go = go_reg;
	assign lnk.arg_wdata = launch_reg;

	// Parameter block storage
	always_ff @(posedge pclk) begin
		if (lnk.mem_req && lnk.mem_we && !ack_reg) begin
			pb_mem[mem_idx] <= lnk.mem_wdata;
		end else if (wr && in_pb) begin
			pb_mem[apb_idx] <= pwdata;
		end
	end

	// One-cycle answer to each block access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_reg <= 1'b0;
			rdata_reg <= scr_pkg::RESET_WORD;
		end else begin
			ack_reg <= lnk.mem_req && !ack_reg;
			rdata_reg <= pb_mem[mem_idx];
		end
	end

	assign lnk.mem_ack = ack_reg;
	assign lnk.mem_rdata = rdata_reg;

	// Result capture and interrupt status
	// Inline result reaches the argument word at the done edge, so take it one cycle later
	assign res_valid = (lnk.done && !launch_reg[scr_pkg::INLINE_BIT]) || res_pend_reg;
	assign res_word = res_pend_reg ? lnk.arg_rdata : lnk.mem_wdata;
	assign irq_set[scr_pkg::IRQ_DONE] = res_valid;
	assign irq_set[scr_pkg::IRQ_ERR] = res_valid
		&& (res_word[scr_pkg::STAT_MSB:scr_pkg::STAT_LSB] == scr_pkg::STAT_ERR);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_pend_reg <= 1'b0;
		end else begin
			res_pend_reg <= lnk.done && launch_reg[scr_pkg::INLINE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_reg <= scr_pkg::RESET_WORD;
			irq_stat_reg <= 2'h0;
		end else begin
			if (res_valid) begin
				result_reg <= res_word;
			end
			// Set wins over a write-one clear
			if (wr && paddr == scr_pkg::A_IRQ_STAT) begin
				irq_stat_reg <= (irq_stat_reg & ~pwdata[1:0]) | irq_set;
			end else begin
				irq_stat_reg <= irq_stat_reg | irq_set;
			end
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

// ==== verif/scr_chk.sv ====
// Link checker for the system-call interpreter and its caller
`timescale 1ns/1ns
`default_nettype none
module scr_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link signals
	input wire logic call_go,
	input wire logic [31:0] arg_wdata,
	input wire logic [31:0] arg_rdata,
	input wire logic busy,
	input wire logic done,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Inline calls that are well formed or refused
	sequence s_inl_reset;
		call_go && arg_wdata[0] && arg_wdata[31:24] == scr_pkg::OPC_RESET && arg_wdata[7:2] == 6'h00;
	endsequence
	sequence s_inl_bad;
		call_go && arg_wdata[0] && arg_wdata[31:24] != scr_pkg::OPC_RESET
			&& arg_wdata[31:24] != scr_pkg::OPC_ERASE_ROW;
	endsequence
	a_inline_reset_ok: assert property (s_inl_reset |-> ##2 done ##1
		arg_rdata == {scr_pkg::STAT_OK, scr_pkg::ERR_NONE})
		else $error("inline reset result wrong");
	a_unknown_opc_err: assert property (s_inl_bad |-> ##2 done ##1
		arg_rdata == {scr_pkg::STAT_ERR, scr_pkg::ERR_OPCODE})
		else $error("unknown opcode result wrong");
	a_busy_after_go: assert property ($rose(busy) |-> $past(call_go))
		else $error("busy rose without a call");
	a_go_when_idle: assert property (call_go |-> !busy)
		else $error("call sent while busy");
	a_ptr_first_read: assert property (call_go && !arg_wdata[0] |=>
		mem_req && !mem_we && mem_addr == $past(arg_wdata))
		else $error("pointer call did not read word0");
	a_req_holds: assert property (mem_req && !mem_ack |=>
		mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
		else $error("memory request dropped early");
	a_ack_next: assert property ($rose(mem_req) |=> mem_ack)
		else $error("memory request not answered");
	a_addr_aligned: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
		else $error("unaligned block address");
	a_wb_status: assert property (mem_req && mem_we |->
		mem_wdata[31:28] == scr_pkg::STAT_OK || mem_wdata[31:28] == scr_pkg::STAT_ERR)
		else $error("bad status in write-back");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Bench: APB-driven caller joined to the interpreter
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, erase_done, serr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, erase_addr;
	logic sys_rq, app_rq, erase_start, erase_hw_hv, flash_read_stall, control_core_stall;
	int failures, n_checks, n_sys, n_app, n_ers, s, a, e, i;
	logic [31:0] arg_t[5] = '{32'h1B00_0001, 32'h1B00_0003, 32'h1B00_0005,
		32'h5500_0001, 32'h1C00_0001};
	logic [31:0] res_t[5] = '{32'hA000_0000, 32'hA000_0000, 32'hF000_0002,
		32'hF000_0001, 32'hF000_0004};
	int sys_t[5] = '{1, 0, 0, 0, 0};
	int app_t[5] = '{0, 1, 0, 0, 0};
	scr_if lnk();
	scr_interp u_scr_interp (.pclk(pclk), .presetn(presetn), .lnk(lnk),
		.sys_reset_req(sys_rq), .app_core_reset_req(app_rq), .erase_start(erase_start),
		.erase_addr(erase_addr), .erase_hw_hv(erase_hw_hv), .erase_done(erase_done),
		.flash_read_stall(flash_read_stall), .control_core_stall(control_core_stall));
	scr_caller u_scr_caller (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .lnk(lnk));
	scr_chk u_scr_chk (.pclk(pclk), .presetn(presetn), .call_go(lnk.call_go),
		.arg_wdata(lnk.arg_wdata), .arg_rdata(lnk.arg_rdata), .busy(lnk.busy),
		.done(lnk.done), .mem_req(lnk.mem_req), .mem_we(lnk.mem_we),
		.mem_addr(lnk.mem_addr), .mem_wdata(lnk.mem_wdata),
		.mem_rdata(lnk.mem_rdata), .mem_ack(lnk.mem_ack));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Count one-cycle request pulses
	always @(posedge pclk) begin
		if (sys_rq === 1'b1) n_sys++;
		if (app_rq === 1'b1) n_app++;
		if (erase_start === 1'b1) n_ers++;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task conclude;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		serr = pslverr;
		if (pready !== 1'b1) begin
			failures++;
			conclude();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task go(input logic [31:0] arg, input logic ptr);
		apb(1'b1, scr_pkg::A_ARG, arg);
		apb(1'b1, scr_pkg::A_CTRL, {30'h0, ptr, 1'b1});
	endtask
	task wait_done;
		int k;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (lnk.done !== 1'b1 && k < 200);
		if (lnk.done !== 1'b1) begin
			failures++;
			conclude();
		end
		repeat (2) @(posedge pclk);
	endtask
	task pulse_done;
		erase_done <= 1'b1;
		@(posedge pclk);
		erase_done <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, erase_done} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, scr_pkg::A_IRQ_MASK, 32'h0);
		chk("mask reset", rd, 32'h0000_0000);
		apb(1'b0, scr_pkg::A_STATUS, 32'h0);
		chk("status reset", rd, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", {31'h0, serr}, 32'h0000_0001);
		chk("unmapped data", rd, 32'h0000_0000);
		// Inline calls: both reset types, bad type, unknown opcode, inline erase
		for (int k = 0; k < 5; k++) begin
			s = n_sys;
			a = n_app;
			go(arg_t[k], 1'b0);
			wait_done();
			apb(1'b0, scr_pkg::A_RESULT, 32'h0);
			chk("inline result", rd, res_t[k]);
			chk("sys reset", 32'(n_sys - s), 32'(sys_t[k]));
			chk("app reset", 32'(n_app - a), 32'(app_t[k]));
		end
		chk("irq masked", {31'h0, irq}, 32'h0000_0000);
		apb(1'b1, scr_pkg::A_IRQ_MASK, 32'h0000_0003);
		chk("irq on", {31'h0, irq}, 32'h0000_0001);
		apb(1'b0, scr_pkg::A_IRQ_STAT, 32'h0);
		chk("irq stat", rd, 32'h0000_0003);
		apb(1'b1, scr_pkg::A_IRQ_STAT, 32'h0000_0003);
		apb(1'b0, scr_pkg::A_IRQ_STAT, 32'h0);
		chk("irq clear", rd, 32'h0000_0000);
		chk("irq off", {31'h0, irq}, 32'h0000_0000);
		// Pointer reset with bit0 set in the block
		a = n_app;
		apb(1'b1, scr_pkg::A_PB_BASE, 32'h1B00_0003);
		go(32'h0, 1'b1);
		wait_done();
		apb(1'b0, scr_pkg::A_PB_BASE, 32'h0);
		chk("ptr result", rd, 32'hA000_0000);
		chk("ptr app reset", 32'(n_app - a), 32'h1);
		// Non-blocking erase, stall reads, hardware sequencing
		e = n_ers;
		apb(1'b1, scr_pkg::A_PB_BASE, 32'h1CFF_0006);
		apb(1'b1, scr_pkg::A_PB_BASE + 8'h04, 32'h0000_1234);
		go(32'h0, 1'b1);
		wait_done();
		apb(1'b0, scr_pkg::A_PB_BASE, 32'h0);
		chk("erase result", rd, 32'hA000_0000);
		chk("erase count", 32'(n_ers - e), 32'h1);
		chk("erase addr", erase_addr, 32'h0000_1200);
		chk("hw hv", {31'h0, erase_hw_hv}, 32'h0000_0001);
		chk("read stall", {31'h0, flash_read_stall}, 32'h0000_0001);
		chk("no core stall", {31'h0, control_core_stall}, 32'h0000_0000);
		apb(1'b1, scr_pkg::A_PB_BASE, 32'h1C00_0006);
		go(32'h0, 1'b1);
		wait_done();
		apb(1'b0, scr_pkg::A_PB_BASE, 32'h0);
		chk("erase busy", rd, 32'hF000_0003);
		pulse_done();
		chk("stall released", {31'h0, flash_read_stall}, 32'h0000_0000);
		// Blocking erase, reads allowed, firmware sequencing
		apb(1'b1, scr_pkg::A_PB_BASE, 32'h1C00_0100);
		go(32'h0, 1'b1);
		i = 0;
		while (control_core_stall !== 1'b1 && i < 50) begin
			@(posedge pclk);
			i++;
		end
		chk("core stall", {31'h0, control_core_stall}, 32'h0000_0001);
		chk("busy blocking", {31'h0, lnk.busy}, 32'h0000_0001);
		chk("no read stall", {31'h0, flash_read_stall}, 32'h0000_0000);
		chk("fw hv", {31'h0, erase_hw_hv}, 32'h0000_0000);
		// Done follows two cycles after the flash reports, so look for it at once
		erase_done <= 1'b1;
		@(posedge pclk);
		erase_done <= 1'b0;
		wait_done();
		apb(1'b0, scr_pkg::A_PB_BASE, 32'h0);
		chk("blocking result", rd, 32'hA000_0000);
		conclude();
	end
endmodule
`default_nettype wire
